/* File: design/hps_host_link_select.sv */
// Host link pin selector: routes the four shared host pins to one of three links.
// Assumes synchronous pin inputs on ref_clk_i and an Avalon-MM master.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module hps_host_link_select (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  // Avalon-MM slave
  input  wire logic [17:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic      [1:0]  avs_response_o,
  // Strap pins and interrupt pin
  input  wire logic        strap_pin0_i,
  input  wire logic        strap_pin1_i,
  input  wire logic        port3_pin3_irq_i,
  output logic             ext_irq1_o,
  // Shared host pins 0..3 (input, output, output enable)
  input  wire logic [3:0]  host_pin_i,
  output logic      [3:0]  host_pin_o,
  output logic      [3:0]  host_pin_oe_o,
  // Fast serial port side
  output logic             fast_serial_receive_o,
  input  wire logic        fast_serial_transmit_i,
  // SPI side
  output logic             spi_nss_o,
  output logic             spi_mosi_o,
  output logic             spi_sck_o,
  input  wire logic        spi_miso_i,
  // I2C side: low-drive requests, sampled levels
  input  wire logic        i2c_scl_low_i,
  input  wire logic        i2c_sda_low_i,
  output logic             i2c_scl_o,
  output logic             i2c_sda_o,
  // Port 7 pins 1 and 2 pass-through
  input  wire logic [1:0]  port7_pin_out_i,
  input  wire logic [1:0]  port7_pin_oe_i,
  output logic      [1:0]  port7_pin_in_o,
  // Status
  output logic      [1:0]  active_link_o
);

  logic [1:0] sel_q;
  logic       valid_q;
  logic       invert_q;
  logic       ack_q;
  logic [31:0] rdata_q;
  logic       hit;
  logic       req;
  logic       wr_fire;
  logic [7:0] reg_view;

  // Register decode, used by both read and write paths
  function automatic logic addr_hit(input logic [17:0] a);
    return a == hps_pkg::HOST_SELECT_CONFIG_ADR;
  endfunction

  assign hit     = addr_hit(avs_address_i);
  assign req     = avs_read_i | avs_write_i;
  // One wait cycle: answer lands the cycle after the request rises
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_fire = avs_write_i & ack_q & hit & avs_byteenable_i[0];

  // Ack toggles off after each completed access, so a held request completes again every second cycle
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_q <= 1'h0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Control fields; firmware fills select from straps
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_q    <= hps_pkg::SEL_RST;
      valid_q  <= hps_pkg::VALID_RST;
      invert_q <= hps_pkg::INVERT_RST;
    end else if (wr_fire) begin
      sel_q    <= avs_writedata_i[hps_pkg::SEL_HI:hps_pkg::SEL_LO];
      valid_q  <= avs_writedata_i[hps_pkg::VALID_BIT];
      invert_q <= avs_writedata_i[hps_pkg::INVERT_BIT];
    end
  end

  // Readback view: strap levels are live, reserved bits zero
  always_comb begin
    reg_view = 8'h00;
    reg_view[hps_pkg::SEL_HI:hps_pkg::SEL_LO] = sel_q;
    reg_view[hps_pkg::VALID_BIT]  = valid_q;
    reg_view[hps_pkg::STRAP0_BIT] = strap_pin0_i;
    reg_view[hps_pkg::STRAP1_BIT] = strap_pin1_i;
    reg_view[hps_pkg::INVERT_BIT] = invert_q;
  end

  // Read data registered at the waiting cycle so it stands at the completing edge
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_q) begin
      rdata_q <= hit ? {24'h00_0000, reg_view} : 32'h0000_0000;
    end
  end

  // Unmapped addresses read zero and answer SLAVEERROR (2'b10)
  always_comb begin
    avs_readdata_o = rdata_q;
    avs_response_o = (req & ack_q & ~hit) ? 2'b10 : 2'b00;
  end

  // Interrupt polarity
  assign ext_irq1_o = port3_pin3_irq_i ^ invert_q;

  // Pin routing; one case item at a time gives exclusivity
  always_comb begin
    host_pin_o            = 4'h0;
    host_pin_oe_o         = 4'h0;
    fast_serial_receive_o = 1'h1;
    spi_nss_o             = 1'h1;
    spi_mosi_o            = 1'h0;
    spi_sck_o             = 1'h0;
    i2c_scl_o             = 1'h1;
    i2c_sda_o             = 1'h1;
    port7_pin_in_o        = 2'h0;
    active_link_o         = hps_pkg::HPS_LINK_NONE;
    if (valid_q) begin
      unique case (hps_pkg::hps_link_t'(sel_q))
        hps_pkg::HPS_LINK_SERIAL: begin
          active_link_o         = sel_q;
          fast_serial_receive_o = host_pin_i[0];
          host_pin_o[1]         = fast_serial_transmit_i;
          host_pin_oe_o[1]      = 1'h1;
          host_pin_o[3:2]       = port7_pin_out_i;
          host_pin_oe_o[3:2]    = port7_pin_oe_i;
          port7_pin_in_o        = host_pin_i[3:2];
        end
        hps_pkg::HPS_LINK_SPI: begin
          active_link_o    = sel_q;
          spi_nss_o        = host_pin_i[0];
          spi_mosi_o       = host_pin_i[1];
          spi_sck_o        = host_pin_i[3];
          host_pin_o[2]    = spi_miso_i;
          host_pin_oe_o[2] = 1'h1;
        end
        hps_pkg::HPS_LINK_I2C: begin
          active_link_o      = sel_q;
          i2c_scl_o          = host_pin_i[0];
          i2c_sda_o          = host_pin_i[1];
          host_pin_oe_o[0]   = i2c_scl_low_i;
          host_pin_oe_o[1]   = i2c_sda_low_i;
          host_pin_o[3:2]    = port7_pin_out_i;
          host_pin_oe_o[3:2] = port7_pin_oe_i;
          port7_pin_in_o     = host_pin_i[3:2];
        end
        hps_pkg::HPS_LINK_NONE: begin
          active_link_o = hps_pkg::HPS_LINK_NONE;
        end
      endcase
    end
  end

  // Checks: every property samples at the rising edge and is quiet in reset.
  // Pin properties look at the combinational routing in the same cycle;
  // register properties look at, or one edge after, the edge where the access completes.

  // Invalid select must leave every pin released
  chk_idle_undriven: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !valid_q |-> host_pin_oe_o == 4'h0)
    else $error("pins driven while link invalid");

  // Invalid select reports no link
  chk_idle_no_link: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !valid_q |-> active_link_o == hps_pkg::HPS_LINK_NONE)
    else $error("link reported while invalid");

  // Reserved code owns no pin
  chk_reserved_quiet: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    sel_q == hps_pkg::HPS_LINK_NONE |-> host_pin_oe_o == 4'h0)
    else $error("reserved select drives pins");

  // Status mirrors the accepted select code
  chk_link_report: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    valid_q |-> active_link_o == sel_q)
    else $error("active link status wrong");

  // Unselected serial receiver sits at idle
  chk_serial_parked: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !(valid_q && sel_q == hps_pkg::HPS_LINK_SERIAL) |-> fast_serial_receive_o)
    else $error("serial receive not idle");

  // Unselected SPI inputs sit at idle
  chk_spi_parked: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !(valid_q && sel_q == hps_pkg::HPS_LINK_SPI) |-> spi_nss_o && !spi_mosi_o && !spi_sck_o)
    else $error("spi inputs not idle");

  // Unselected I2C lines read released
  chk_i2c_parked: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !(valid_q && sel_q == hps_pkg::HPS_LINK_I2C) |-> i2c_scl_o && i2c_sda_o)
    else $error("i2c lines not idle");

  // Open drain never drives a one
  chk_i2c_opendrain: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    valid_q && sel_q == hps_pkg::HPS_LINK_I2C |-> host_pin_o[1:0] == 2'h0)
    else $error("i2c pin driven high");

  // Enable follows the pull-low requests
  chk_i2c_low_req: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    valid_q && sel_q == hps_pkg::HPS_LINK_I2C |-> host_pin_oe_o[1:0] == {i2c_sda_low_i, i2c_scl_low_i})
    else $error("i2c enable wrong");

  // I2C sees the line levels of pins 0 and 1
  chk_i2c_levels: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    valid_q && sel_q == hps_pkg::HPS_LINK_I2C |-> i2c_scl_o == host_pin_i[0] && i2c_sda_o == host_pin_i[1])
    else $error("i2c levels wrong");

  // Serial transmit is push-pull on pin 1
  chk_serial_tx: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    valid_q && sel_q == hps_pkg::HPS_LINK_SERIAL |-> host_pin_oe_o[1:0] == 2'h2 && host_pin_o[1] == fast_serial_transmit_i)
    else $error("serial pin direction wrong");

  // Serial receive comes from pin 0
  chk_serial_rx: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    valid_q && sel_q == hps_pkg::HPS_LINK_SERIAL |-> fast_serial_receive_o == host_pin_i[0])
    else $error("serial receive wrong");

  // Port 7 owns pins 2 and 3 under the serial and I2C links
  chk_port7_route: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    valid_q && (sel_q == hps_pkg::HPS_LINK_SERIAL || sel_q == hps_pkg::HPS_LINK_I2C) |->
      host_pin_o[3:2] == port7_pin_out_i && host_pin_oe_o[3:2] == port7_pin_oe_i && port7_pin_in_o == host_pin_i[3:2])
    else $error("port7 routing wrong");

  // Port 7 reads zero when not routed
  chk_port7_parked: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !(valid_q && (sel_q == hps_pkg::HPS_LINK_SERIAL || sel_q == hps_pkg::HPS_LINK_I2C)) |-> port7_pin_in_o == 2'h0)
    else $error("port7 input not parked");

  // SPI drives only its data-out pin
  chk_spi_miso: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    valid_q && sel_q == hps_pkg::HPS_LINK_SPI |-> host_pin_oe_o == 4'h4 && host_pin_o[2] == spi_miso_i)
    else $error("spi pin direction wrong");

  // SPI inputs come from pins 0, 1 and 3
  chk_spi_inputs: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    valid_q && sel_q == hps_pkg::HPS_LINK_SPI |-> spi_nss_o == host_pin_i[0] && spi_mosi_o == host_pin_i[1] && spi_sck_o == host_pin_i[3])
    else $error("spi inputs wrong");

  // Setting the invert bit flips the pin at once
  chk_irq_polarity: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    $rose(invert_q) |-> ext_irq1_o != port3_pin3_irq_i)
    else $error("irq not inverted");

  // Clear invert bit passes the pin unchanged
  chk_irq_plain: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !invert_q |-> ext_irq1_o == port3_pin3_irq_i)
    else $error("irq altered while not inverted");

  // Strap bits are caught in the waiting cycle
  chk_strap_read: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    avs_read_i && !ack_q && hit |=> rdata_q[5] == $past(strap_pin1_i) && rdata_q[3] == $past(strap_pin0_i))
    else $error("strap readback wrong");

  // Select and valid land on the completing edge
  chk_write_lands: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    wr_fire |=> sel_q == $past(avs_writedata_i[1:0]) && valid_q == $past(avs_writedata_i[2]))
    else $error("select write lost");

  // Invert bit lands on the completing edge
  chk_write_invert: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    wr_fire |=> invert_q == $past(avs_writedata_i[hps_pkg::INVERT_BIT]))
    else $error("invert write lost");

  // Unmapped writes leave the fields alone
  chk_refused_write: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    avs_write_i && ack_q && !hit |=> $stable(sel_q) && $stable(valid_q) && $stable(invert_q))
    else $error("unmapped write changed fields");

  // Unmapped accesses answer with an error code
  chk_unmapped_resp: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    req && ack_q && !hit |-> avs_response_o == 2'h2)
    else $error("unmapped response missing");

  // Exactly one wait cycle per access
  chk_one_wait: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    $rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer late");

endmodule

/* File: design/hps_pkg.sv */
// Package for the host link pin selector: register map, field positions, reset values.
// Assumes a 32-bit Avalon-MM slave with word-aligned registers.
package hps_pkg;
  // Register index as printed; byte address is four times the index
  localparam logic [15:0] HOST_SELECT_CONFIG_IDX = 16'h6103;
  localparam logic [17:0] HOST_SELECT_CONFIG_ADR = {HOST_SELECT_CONFIG_IDX, 2'h0};
  localparam int          ADDR_W                 = 18;

  // Field positions
  localparam int SEL_LO      = 0;
  localparam int SEL_HI      = 1;
  localparam int VALID_BIT   = 2;
  localparam int STRAP0_BIT  = 3;
  localparam int STRAP1_BIT  = 5;
  localparam int INVERT_BIT  = 7;

  // Reset values
  localparam logic [1:0] SEL_RST    = 2'h0;
  localparam logic       VALID_RST  = 1'h0;
  localparam logic       INVERT_RST = 1'h0;

  // Link select codes
  typedef enum logic [1:0] {
    HPS_LINK_SERIAL = 2'b00,
    HPS_LINK_SPI    = 2'b01,
    HPS_LINK_I2C    = 2'b10,
    HPS_LINK_NONE   = 2'b11
  } hps_link_t;
endpackage

/* File: verification/hps_host_model.sv */
// Host-side model of the four shared pins.
// Assumes the selector's pin outputs and enables.
`timescale 1ns/1ps
module hps_host_model (
  input  wire logic [3:0] pin_o_i,
  input  wire logic [3:0] pin_oe_i,
  input  wire logic [3:0] drive_i,
  output logic      [3:0] pin_lvl_o
);
  // Device wins where enabled; a real host would contend, so ours yields
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      pin_lvl_o[k] = pin_oe_i[k] ? pin_o_i[k] : drive_i[k];
    end
  end
endmodule

/* File: verification/hps_host_link_select_tb.sv */
// Bench for the host link pin selector: register access, routing, gating.
// Assumes one clock and the host model on the shared pins.
`timescale 1ns/1ps
module hps_host_link_select_tb;
  localparam logic [17:0] A = hps_pkg::HOST_SELECT_CONFIG_ADR;
  localparam logic [3:0]  EOE [4] = '{4'he, 4'h4, 4'hd, 4'h0};
  localparam logic [3:0]  EO [4]  = '{4'ha, 4'h4, 4'h8, 4'h0};
  // Expected {mosi, sck, sda, port7 in} per select code
  localparam logic [4:0]  EPIN [4] = '{5'h06, 5'h1c, 5'h06, 5'h04};
  logic        clk, rst_n, rd, wr, s0, s1, irq, tx;
  logic [17:0] adr;
  logic [31:0] wd, rdv, rdata;
  logic [3:0]  drv, lvl, po, poe, be;
  logic [1:0]  resp, rsp, p7o, p7e, ilo, p7in, act;
  logic        wt, irq_o, rx, nss, mosi, sck, scl, sda;
  int          fails, n_compared, cyc;

  hps_host_link_select u_hps_host_link_select (
    .ref_clk_i(clk), .arst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
    .avs_response_o(resp), .strap_pin0_i(s0), .strap_pin1_i(s1), .port3_pin3_irq_i(irq),
    .ext_irq1_o(irq_o), .host_pin_i(lvl), .host_pin_o(po), .host_pin_oe_o(poe),
    .fast_serial_receive_o(rx), .fast_serial_transmit_i(tx), .spi_nss_o(nss), .spi_mosi_o(mosi),
    .spi_sck_o(sck), .spi_miso_i(tx), .i2c_scl_low_i(ilo[0]), .i2c_sda_low_i(ilo[1]),
    .i2c_scl_o(scl), .i2c_sda_o(sda), .port7_pin_out_i(p7o), .port7_pin_oe_i(p7e),
    .port7_pin_in_o(p7in), .active_link_o(act));
  hps_host_model u_hps_host_model (.pin_o_i(po), .pin_oe_i(poe), .drive_i(drv), .pin_lvl_o(lvl));

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One Avalon cycle; the wait is bounded only by the run timeout
  task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wt !== 1'b0);
    rdv = rdata;
    rsp = resp;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic t_reset;
    check("oe", 0, poe);
    bus(0, A, 8'h0);
    check("cfg", 0, rdv);
    check("rsp", 0, rsp);
  endtask

  // Firmware copies the straps into the select field and sets valid in the same write
  task automatic t_links;
    for (int k = 0; k < 4; k++) begin
      {s1, s0} <= k[1:0];
      bus(0, A, 8'h0);
      bus(1, A, {5'h0, 1'b1, rdv[5], rdv[3]});
      bus(0, A, 8'h0);
      check("cfg", {k[1], 1'b0, k[0], 1'b1, k[1:0]}, rdv);
      check("oe", EOE[k], poe);
      check("o", EO[k], po & poe);
      check("act", k, act);
      check("rcv", 0, k == 0 ? rx : k == 1 ? nss : k == 2 ? scl : p7in);
      check("pins", EPIN[k], {mosi, sck, sda, p7in});
    end
  endtask

  task automatic t_gate;
    bus(1, A, 8'h01);
    check("oe", 0, poe);
    check("act", 3, act);
  endtask

  task automatic t_invert;
    for (int b = 0; b < 2; b++) begin
      bus(1, A, {b[0], 7'h0});
      irq <= 1'b1;
      @(negedge clk);
      check("irq", !b[0], irq_o);
      @(posedge clk);
      irq <= 1'b0;
      @(negedge clk);
      check("irq0", b[0], irq_o);
    end
  endtask

  // Unmapped place: error response, zero data, no side effect
  task automatic t_unmapped;
    bus(1, A + 18'h4, 8'h06);
    bus(0, A + 18'h4, 8'h0);
    check("rsp", 2, rsp);
    check("rd", 0, rdv);
    bus(0, A, 8'h0);
    check("cfg", 8'ha8, rdv[7:0]);
    // Low byte lane disabled: write must be ignored
    be <= 4'he;
    bus(1, A, 8'h07);
    be <= 4'hf;
    bus(0, A, 8'h0);
    check("cfg_be", 8'ha8, rdv[7:0]);
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  // Ceiling well above the fewer than a hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    {rst_n, rd, wr, s0, s1, irq, tx, adr, wd} = '0;
    {drv, p7o, p7e, ilo} = {4'ha, 2'b10, 2'b11, 2'b01};
    tx = 1'b1;
    be = 4'hf;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_links();
    t_gate();
    t_invert();
    t_unmapped();
    final_report();
  end
endmodule
